// ==== rtl/peripheral_interrupt_controller.sv ====
`timescale 1ns/1ps
module peripheral_interrupt_controller (
    input  wire logic                         core_clk,
    input  wire logic                         rst,
    // wishbone classic slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // event sources, one-cycle pulses on core_clk
    input  wire logic [pic_pkg::N_PERIPH-1:0] periph_event,
    input  wire logic                         timer_event,
    input  wire logic                         serial_port_zero_tx_event,
    input  wire logic                         serial_port_zero_rx_event,
    input  wire logic                         serial_port_one_tx_event,
    input  wire logic                         serial_port_one_rx_event,
    // asynchronous pins, active low
    input  wire logic                         external_line_zero_n,
    input  wire logic                         external_line_one_n,
    // program sequencer side
    input  wire logic                         return_from_interrupt,
    output logic                              core_irq_pulse,
    output logic      [15:0]                  core_irq_vector,
    output logic                              peripheral_line_to_core
);
    import pic_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                   ack;
        logic [31:0]            rdata;
        logic [CORE_MASK_W-1:0] core_mask;
        logic [SENSE_W-1:0]     sense;
        logic [N_PERIPH-1:0]    pmask;
        logic [N_CORE-1:0]      latch;
        logic [N_CORE-1:0]      svc;
        logic [2:0]             line_prev;
        logic                   irq_pulse;
        logic [15:0]            irq_vec;
        logic                   pline;
        logic                   vec_live;
    } ctl_t;

    ctl_t              r_reg;
    ctl_t              r_next;

    pic_if             pic ();

    logic [1:0]        pins_sync;
    logic              bus_hit;
    logic              wr_now;
    logic              rd_now;
    logic [31:0]       wr_word;
    logic [31:0]       fc_word;
    logic [N_CORE-1:0] clr_bits;
    logic [N_CORE-1:0] frc_bits;
    logic [2:0]        line_act;
    logic [2:0]        line_edge;
    logic [2:0]        edge_mode;
    logic [N_CORE-1:0] set_evt;
    logic [N_CORE-1:0] level_req;
    logic [N_CORE-1:0] enabled;
    logic [N_CORE-1:0] pend;
    logic [CIDX_W:0]   win_i;
    logic [CIDX_W:0]   svc_i;
    logic [N_CORE-1:0] svc_left;
    logic [N_CORE-1:0] take_hot;
    logic              allow;

    ////////////////////////////////////////////////////////////////////////////
    // leaves

    // external lines come from pins, so they pass two flops first
    pin_sync #(
        .W (2)
    ) u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      ({external_line_one_n, external_line_zero_n}),
        .synced   (pins_sync)
    );

    peripheral_irq_arbiter u_arbiter (
        .core_clk (core_clk),
        .rst      (rst),
        .pic      (pic.arb)
    );

    assign pic.req  = periph_event;
    assign pic.mask = r_reg.pmask;

    ////////////////////////////////////////////////////////////////////////////
    // bus access decode

    // writes and read side effects land on the edge that sees ack high
    always_comb begin
        bus_hit      = wb_cyc_i & wb_stb_i;
        wr_now       = bus_hit & wb_we_i & r_reg.ack;
        rd_now       = bus_hit & ~wb_we_i & r_reg.ack;
        pic.vec_read = rd_now & (wb_adr_i == ADR_PVECTOR) & r_reg.vec_live; // stale capture releases nothing
        fc_word      = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
        clr_bits     = (wr_now && wb_adr_i == ADR_FORCE_CLR) ? fc_word[N_CORE-1:0] : '0;
        frc_bits     = (wr_now && wb_adr_i == ADR_FORCE_CLR) ? fc_word[FORCE_LSB +: N_CORE] : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // core interrupt sources

    always_comb begin
        // lines are active low; the peripheral line is already on this clock
        line_act  = {pic.line, ~pins_sync[1], ~pins_sync[0]};
        line_edge = line_act & ~r_reg.line_prev;
        edge_mode = {r_reg.sense[SENSE_EDGE2], r_reg.sense[SENSE_EDGE1], r_reg.sense[SENSE_EDGE0]};

        set_evt            = '0;
        set_evt[CI_TIMER]  = timer_event;
        set_evt[CI_S1RX]   = serial_port_one_rx_event | (edge_mode[0] & line_edge[0]);
        set_evt[CI_S1TX]   = serial_port_one_tx_event | (edge_mode[1] & line_edge[1]);
        set_evt[CI_S0RX]   = serial_port_zero_rx_event;
        set_evt[CI_S0TX]   = serial_port_zero_tx_event;
        // all peripherals share one core entry
        set_evt[CI_PERIPH] = edge_mode[2] & line_edge[2];
        // software entries only from force bits
        set_evt[CI_SW0]    = 1'b0;
        set_evt[CI_SW1]    = 1'b0;

        // level lines request for as long as they are held
        level_req            = '0;
        level_req[CI_S1RX]   = ~edge_mode[0] & line_act[0];
        level_req[CI_S1TX]   = ~edge_mode[1] & line_act[1];
        level_req[CI_PERIPH] = ~edge_mode[2] & line_act[2];
    end

    ////////////////////////////////////////////////////////////////////////////
    // core priority and nesting

    always_comb begin
        enabled = r_reg.core_mask[CORE_MASK_LSB +: N_CORE];
        pend    = (r_reg.latch | level_req) & enabled;
        win_i   = top_index(pend);
        svc_i   = top_index(r_reg.svc);
        allow   = win_i[CIDX_W] &
                  (~svc_i[CIDX_W] | (r_reg.sense[SENSE_NEST] & (win_i[CIDX_W-1:0] > svc_i[CIDX_W-1:0])));
        take_hot = '0;
        if (allow) begin
            take_hot[win_i[CIDX_W-1:0]] = 1'b1;
        end
        // a return closes the innermost routine
        svc_left = r_reg.svc;
        if (return_from_interrupt && svc_i[CIDX_W]) begin
            svc_left[svc_i[CIDX_W-1:0]] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        r_next = r_reg;

        // bus answer: ack for one cycle, data captured with it
        r_next.ack = bus_hit & ~r_reg.ack;
        if (bus_hit && !r_reg.ack) begin
            // a vector only counts as read if the arbiter held it at capture
            r_next.vec_live = pic.line;
            unique case (wb_adr_i)
                ADR_CORE_MASK: r_next.rdata = 32'(r_reg.core_mask);
                ADR_SENSE:     r_next.rdata = 32'(r_reg.sense);
                ADR_PMASK:     r_next.rdata = 32'(r_reg.pmask);
                ADR_PVECTOR:   r_next.rdata = 32'(pic.vector);
                ADR_STATUS:    r_next.rdata = {16'h0000, r_reg.svc, r_reg.latch};
                default:       r_next.rdata = 32'h0000_0000;
            endcase
        end

        // register writes, byte lanes honoured
        wr_word = 32'h0000_0000;
        if (wr_now) begin
            unique case (wb_adr_i)
                ADR_CORE_MASK: begin
                    wr_word          = lane_merge(32'(r_reg.core_mask), wb_dat_i, wb_sel_i);
                    r_next.core_mask = wr_word[CORE_MASK_W-1:0];
                end
                ADR_SENSE: begin
                    wr_word      = lane_merge(32'(r_reg.sense), wb_dat_i, wb_sel_i);
                    r_next.sense = wr_word[SENSE_W-1:0];
                end
                ADR_PMASK: begin
                    wr_word      = lane_merge(32'(r_reg.pmask), wb_dat_i, wb_sel_i);
                    r_next.pmask = wr_word[N_PERIPH-1:0];
                end
                default: begin
                    wr_word = 32'h0000_0000;
                end
            endcase
        end

        // force latch
        // new events win over a clear in the same cycle
        r_next.latch     = (r_reg.latch & ~clr_bits & ~take_hot) | set_evt | frc_bits;
        r_next.svc       = svc_left | take_hot;
        r_next.line_prev = line_act;

        r_next.irq_pulse = allow;
        if (allow) begin
            r_next.irq_vec = CORE_VEC[win_i[CIDX_W-1:0]];
        end
        r_next.pline = pic.line;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r_reg           <= '0;
            r_reg.core_mask <= CORE_MASK_RST;
            r_reg.sense     <= SENSE_RST;
            r_reg.pmask     <= PMASK_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wb_dat_o                = r_reg.rdata;
    assign wb_ack_o                = r_reg.ack;
    assign core_irq_pulse          = r_reg.irq_pulse;
    assign core_irq_vector         = r_reg.irq_vec;
    assign peripheral_line_to_core = r_reg.pline;
endmodule // peripheral_interrupt_controller

// ==== rtl/peripheral_irq_arbiter.sv ====
`timescale 1ns/1ps
module peripheral_irq_arbiter #(
    parameter pic_pkg::prio_map_t PRIO_POS = pic_pkg::PRIO_POS_DEFAULT
) (
    input  wire logic core_clk,
    input  wire logic rst,
    pic_if.arb        pic
);
    import pic_pkg::*;

    typedef struct packed {
        logic [N_PERIPH-1:0] pend;
        logic                loaded;
        logic [PIDX_W-1:0]   src;
        logic [15:0]         vec;
    } arb_t;

    arb_t                r_reg;
    arb_t                r_next;
    logic [N_PERIPH-1:0] req_pos;
    logic [N_PERIPH-1:0] live;
    logic [PIDX_W-1:0]   win;
    logic                found;

    always_comb begin
        r_next  = r_reg;
        req_pos = '0;
        for (int s = 0; s < N_PERIPH; s++) begin
            req_pos[PRIO_POS[s]] = pic.req[s];
        end
        live  = r_reg.pend & pic.mask;
        win   = '0;
        found = 1'b0;
        for (int i = N_PERIPH - 1; i >= 0; i--) begin
            if (live[i]) begin
                win   = PIDX_W'(i);
                found = 1'b1;
            end
        end
        if (pic.vec_read && r_reg.loaded) begin
            r_next.loaded          = 1'b0;
            r_next.pend[r_reg.src] = 1'b0;
        end else if (!r_reg.loaded && found) begin
            r_next.loaded = 1'b1;
            r_next.src    = win;
            r_next.vec    = PVEC_BASE + PVEC_STEP * 16'(win);
        end
        // a request in the release cycle stays pending
        r_next.pend = r_next.pend | req_pos;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign pic.line   = r_reg.loaded;
    assign pic.vector = r_reg.vec;
endmodule // peripheral_irq_arbiter

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 2
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] synced
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t r_reg;
    sync_t r_next;

    // first stage feeds only the second; lines idle high
    always_comb begin
        r_next    = r_reg;
        r_next.s1 = pin;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r_reg <= '1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign synced = r_reg.s2;
endmodule // pin_sync

// ==== shared/pic_if.sv ====
`timescale 1ns/1ps
// link between the register/core logic and the peripheral arbiter
interface pic_if;
    logic [pic_pkg::N_PERIPH-1:0] req;
    logic [pic_pkg::N_PERIPH-1:0] mask;
    logic                         vec_read;
    logic                         line;
    logic [15:0]                  vector;

    modport arb (input req, input mask, input vec_read, output line, output vector);
    modport ctl (output req, output mask, output vec_read, input line, input vector);
endinterface

// ==== shared/pic_pkg.sv ====
// What this block does
// - peripheral reaches core only if core mask bit 9 and its source bit set
// - every source has its own mask bit, except lines zero and one, which use serial port one's; one enables, zero masks
// - writing one to force/clear bits 0..7 clears that latched core interrupt
// - writing one to force/clear bits 8..15 sets that core interrupt's pending latch
// - software interrupts come only from force/clear bits 11 and 12
// - control bits 0..2 pick edge (one) or level (zero) for lines zero..two
// - control bit 4 allows nesting; otherwise no pre-emption of a running routine
// - each source, bar lines zero and one, owns a four-word vector slot within 0x0000..0x005F
// - timer, serial port and software interrupts branch to their own slot
// - all eleven peripheral sources branch to shared vector 0x0004
// - vector register gets the requesting source's address, 0x0030..0x0058
// - with several pending, the highest-priority unmasked source is loaded
// - loaded vector holds until the processor reads it
// - no further peripheral interrupt is signalled until the vector is read
// - peripheral priority runs from 0x0030 down to 0x0058 in table order
package pic_pkg;
    localparam int N_PERIPH = 11;
    localparam int N_CORE   = 8;
    localparam int PIDX_W   = 4;
    localparam int CIDX_W   = 3;

    // register byte offsets on the bus
    localparam logic [7:0] ADR_CORE_MASK = 8'h00;
    localparam logic [7:0] ADR_FORCE_CLR = 8'h04;
    localparam logic [7:0] ADR_SENSE     = 8'h08;
    localparam logic [7:0] ADR_PMASK     = 8'h0C;
    localparam logic [7:0] ADR_PVECTOR   = 8'h10;
    localparam logic [7:0] ADR_STATUS    = 8'h14;

    // field layout
    localparam int CORE_MASK_W   = 10;
    localparam int CORE_MASK_LSB = 2;
    localparam int SENSE_W       = 5;
    localparam int SENSE_NEST    = 4;
    localparam int SENSE_EDGE0   = 0;
    localparam int SENSE_EDGE1   = 1;
    localparam int SENSE_EDGE2   = 2;
    localparam int FORCE_LSB     = 8;

    localparam logic [CORE_MASK_W-1:0] CORE_MASK_RST = 10'h000;
    localparam logic [SENSE_W-1:0]     SENSE_RST     = 5'h00;
    localparam logic [N_PERIPH-1:0]    PMASK_RST     = 11'h000;

    // core interrupt index, priority rises with the index
    localparam int CI_TIMER    = 0;
    localparam int CI_S1RX     = 1;
    localparam int CI_S1TX     = 2;
    localparam int CI_SW0      = 3;
    localparam int CI_SW1      = 4;
    localparam int CI_S0RX     = 5;
    localparam int CI_S0TX     = 6;
    localparam int CI_PERIPH   = 7;

    localparam logic [15:0] CORE_VEC [N_CORE] = '{
        16'h0028, 16'h0024, 16'h0020, 16'h001C, 16'h0018, 16'h0014, 16'h0010, 16'h0004};
    localparam logic [15:0] PVEC_BASE = 16'h0030;
    localparam logic [15:0] PVEC_STEP = 16'h0004;

    // source input index to priority position, identity by default
    typedef int unsigned prio_map_t [N_PERIPH];
    localparam prio_map_t PRIO_POS_DEFAULT = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10};

    // highest set bit of a core vector: {found, index}
    function automatic logic [CIDX_W:0] top_index(input logic [N_CORE-1:0] v);
        logic [CIDX_W:0] r;
        r = '0;
        for (int i = 0; i < N_CORE; i++) begin
            if (v[i]) r = {1'b1, CIDX_W'(i)};
        end
        return r;
    endfunction

    // byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) r[b*8 +: 8] = d[b*8 +: 8];
        end
        return r;
    endfunction
endpackage

// ==== test/pic_properties.sv ====
`timescale 1ns/1ps
module pic_properties
    import pic_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        return_from_interrupt,
    input wire logic        core_irq_pulse,
    input wire logic [15:0] core_irq_vector,
    input wire logic        peripheral_line_to_core
);
    logic wr_ack;
    logic vec_rd;
    logic mask9_reg;
    logic nest_reg;
    logic busy_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    assign wr_ack = wb_ack_o && wb_cyc_i && wb_we_i;
    assign vec_rd = wb_ack_o && wb_cyc_i && !wb_we_i && wb_adr_i == ADR_PVECTOR;

    // shadow of bit 9 and nesting; busy only tracks one level, enough with nesting off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask9_reg <= 1'b0;
            nest_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            if (wr_ack && wb_adr_i == ADR_CORE_MASK && wb_sel_i[1]) mask9_reg <= wb_dat_i[9];
            if (wr_ack && wb_adr_i == ADR_SENSE && wb_sel_i[0]) nest_reg <= wb_dat_i[SENSE_NEST];
            busy_reg <= return_from_interrupt ? 1'b0 : (core_irq_pulse ? 1'b1 : busy_reg);
        end
    end

    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_vector_held: assert property (!core_irq_pulse |-> $stable(core_irq_vector))
        else $error("core vector moved without a take");
    chk_vector_table: assert property (core_irq_pulse |-> core_irq_vector inside {16'h0004, 16'h0010,
        16'h0014, 16'h0018, 16'h001C, 16'h0020, 16'h0024, 16'h0028})
        else $error("core vector outside its slot table");
    chk_periph_gate: assert property (core_irq_pulse && core_irq_vector == 16'h0004 |-> $past(mask9_reg))
        else $error("peripheral taken with line enable off");
    chk_vec_range: assert property (vec_rd && wb_dat_o != 32'h0 |-> wb_dat_o[15:0] >= 16'h0030
        && wb_dat_o[15:0] <= 16'h0058 && wb_dat_o[1:0] == 2'h0)
        else $error("peripheral vector out of range");
    chk_line_holds: assert property (peripheral_line_to_core && !vec_rd && !$past(vec_rd)
        |=> peripheral_line_to_core)
        else $error("peripheral line dropped without a vector read");
    chk_line_taken: assert property ($rose(peripheral_line_to_core) && mask9_reg && !busy_reg
        |-> ##[0:1] (core_irq_pulse && core_irq_vector == 16'h0004))
        else $error("peripheral line not taken at the shared slot");
    chk_no_preempt: assert property (core_irq_pulse && busy_reg |-> nest_reg)
        else $error("routine pre-empted with nesting off");

    cover property (core_irq_pulse && core_irq_vector == 16'h0004);
    cover property (core_irq_pulse && busy_reg);
    cover property (vec_rd && wb_dat_o != 32'h0);
endmodule // pic_properties

bind peripheral_interrupt_controller pic_properties u_pic_properties (.core_clk, .rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .return_from_interrupt, .core_irq_pulse,
    .core_irq_vector, .peripheral_line_to_core);

// ==== test/sequencer_model.sv ====
`timescale 1ns/1ps
module sequencer_model #(
    parameter int LAT = 6
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic core_irq_pulse,
    input  wire logic hold,
    output logic      return_from_interrupt
);
    int depth_reg;
    int wait_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            depth_reg <= 0;
            wait_reg <= 0;
            return_from_interrupt <= 1'b0;
        end else if (core_irq_pulse) begin
            depth_reg <= depth_reg + 1;
            wait_reg <= 0;
            return_from_interrupt <= 1'b0;
        end else if (depth_reg > 0 && !hold && wait_reg >= LAT) begin
            depth_reg <= depth_reg - 1;
            wait_reg <= 0;
            return_from_interrupt <= 1'b1;
        end else begin
            wait_reg <= wait_reg + 1;
            return_from_interrupt <= 1'b0;
        end
    end
endmodule // sequencer_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import pic_pkg::*;
    logic        core_clk;
    logic        rst;
    logic        cyc;
    logic        we;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [10:0] pev;
    logic [4:0]  src;
    logic [1:0]  xl_n;
    logic        hold;
    logic        rfi;
    logic        irq;
    logic [15:0] ivec;
    logic        pline;
    logic [31:0] q;
    int          n;
    int          n_errors;
    int          num_checks;

    peripheral_interrupt_controller dut (.core_clk(core_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .periph_event(pev), .timer_event(src[0]), .serial_port_zero_rx_event(src[1]),
        .serial_port_zero_tx_event(src[2]), .serial_port_one_rx_event(src[3]), .serial_port_one_tx_event(src[4]),
        .external_line_zero_n(xl_n[0]), .external_line_one_n(xl_n[1]), .return_from_interrupt(rfi),
        .core_irq_pulse(irq), .core_irq_vector(ivec), .peripheral_line_to_core(pline));
    sequencer_model seq (.core_clk(core_clk), .rst(rst), .core_irq_pulse(irq), .hold(hold),
        .return_from_interrupt(rfi));

    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic timeout();
        n_errors++;
        $display("unexpected at %0t: wait ran out", $time);
        test_done();
    endtask

    // one classic cycle; request held until the edge that samples ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge core_clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) timeout();
        q = rdat;
        cyc <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wait_irq(input logic [15:0] v);
        int k;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (irq !== 1'b1 && k < 40);
        if (irq !== 1'b1) timeout();
        check({16'h0, ivec}, {16'h0, v});
    endtask

    task automatic count_irq(input int c);
        n = 0;
        repeat (c) begin
            @(posedge core_clk);
            if (irq === 1'b1) n++;
        end
    endtask

    task automatic fire(input logic [10:0] p, input logic [4:0] s);
        pev <= p;
        src <= s;
        @(posedge core_clk);
        pev <= '0;
        src <= '0;
        @(posedge core_clk);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        logic [7:0]  ra [5];
        logic [31:0] rv [5];
        logic [15:0] tv [5];
        logic [15:0] pv [4];
        ra = '{ADR_CORE_MASK, ADR_SENSE, ADR_PMASK, ADR_PVECTOR, 8'h20};
        rv = '{32'h03FF, 32'h001F, 32'h07FF, 32'h0, 32'h0};
        tv = '{16'h0028, 16'h001C, 16'h0018, 16'h0014, 16'h0010};
        pv = '{16'h0034, 16'h0030, 16'h0044, 16'h0058};
        rst = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
        pev = '0;
        src = '0;
        xl_n = 2'h3;
        hold = 1'b0;
        n_errors = 0;
        num_checks = 0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // reset values, widths, read-only and unmapped places
        wb(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ra[i], 32'h0);
            check(q, 32'h0);
            wb(1'b1, ra[i], 32'hFFFF_FFFF);
            wb(1'b0, ra[i], 32'h0);
            check(q, rv[i]);
            wb(1'b1, ra[i], 32'h0);
        end
        wb(1'b0, ADR_FORCE_CLR, 32'h0);
        check(q, 32'h0);
        $display("test registers done");
        // force sets software latches, events their own
        wb(1'b1, ADR_FORCE_CLR, 32'h1800);
        fire(11'h0, 5'h07);
        wb(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h0079);
        wb(1'b1, ADR_FORCE_CLR, 32'h0008);
        wb(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h0071);
        wb(1'b1, ADR_FORCE_CLR, 32'h00FF);
        wb(1'b0, ADR_STATUS, 32'h0);
        check(q, 32'h0);
        $display("test force clear done");
        // own slots for timer, serial and software sources
        wb(1'b1, ADR_CORE_MASK, 32'h01FC);
        for (int i = 0; i < 5; i++) begin
            if (i == 1 || i == 2) wb(1'b1, ADR_FORCE_CLR, 32'h0800 << (i - 1));
            else fire(11'h0, i == 0 ? 5'h01 : (i == 3 ? 5'h02 : 5'h04));
            wait_irq(tv[i]);
            repeat (12) @(posedge core_clk);
        end
        $display("test core slots done");
        // both masks gate; line kept level
        wb(1'b1, ADR_PMASK, 32'h0010);
        fire(11'h018, 5'h0);
        count_irq(12);
        check(32'(n), 32'h0);
        check(32'(pline), 32'h1);
        wb(1'b1, ADR_CORE_MASK, 32'h03FC);
        wait_irq(16'h0004);
        wb(1'b0, ADR_PVECTOR, 32'h0);
        check(q, 32'h0040);
        count_irq(15);
        check(32'(n), 32'h0);
        check(32'(pline), 32'h0);
        wb(1'b1, ADR_PMASK, 32'h0018);
        wait_irq(16'h0004);
        wb(1'b0, ADR_PVECTOR, 32'h0);
        check(q, 32'h003C);
        $display("test masks done");
        wb(1'b1, ADR_PMASK, 32'h07FF);
        fire(11'h422, 5'h0);
        repeat (4) @(posedge core_clk);
        fire(11'h001, 5'h0);
        for (int i = 0; i < 4; i++) begin
            repeat (3) @(posedge core_clk);
            wb(1'b0, ADR_PVECTOR, 32'h0);
            check(q, {16'h0, pv[i]});
        end
        $display("test priority done");
        // level lines retrigger while low, edge lines once
        for (int i = 0; i < 2; i++) begin
            wb(1'b1, ADR_CORE_MASK, 32'h0008 << i);
            for (int e = 0; e < 2; e++) begin
                wb(1'b1, ADR_SENSE, 32'(e << i));
                xl_n[i] <= 1'b0;
                count_irq(60);
                xl_n[i] <= 1'b1;
                check(32'(n > 1), 32'(e == 0));
                check(32'(n > 0), 32'h1);
                repeat (20) @(posedge core_clk);
            end
        end
        $display("test sensitivity done");
        // blocked while in service, taken once nesting is on
        wb(1'b1, ADR_SENSE, 32'h0);
        wb(1'b1, ADR_CORE_MASK, 32'h0044);
        hold <= 1'b1;
        fire(11'h0, 5'h01);
        wait_irq(16'h0028);
        wb(1'b1, ADR_FORCE_CLR, 32'h1000);
        count_irq(15);
        check(32'(n), 32'h0);
        wb(1'b1, ADR_SENSE, 32'h0010);
        wait_irq(16'h0018);
        hold <= 1'b0;
        repeat (40) @(posedge core_clk);
        $display("test nesting done");
        test_done();
    end
endmodule // testbench
